/* hw/trip_timer_consts.vh */
`ifndef TRIP_TIMER_CONSTS_VH
`define TRIP_TIMER_CONSTS_VH

// ========================================
// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_DEF_DELAY 8'h04
`define REG_TIME_DIAL 8'h08
`define REG_CONST_A 8'h0C
`define REG_CONST_B 8'h10
`define REG_CONST_C 8'h14
`define REG_STATUS 8'h18
`define REG_ELAPSED 8'h1C
`define REG_INV_DELAY 8'h20

// ========================================
// control fields
`define CTRL_MODE_BIT 0
`define CTRL_SERIES_BIT 1
`define CTRL_CURVE_LSB 4
`define CTRL_CURVE_MSB 6

// ========================================
// status fields
`define STAT_START_BIT 0
`define STAT_TRIP_BIT 1
`define STAT_BLOCKED_BIT 2
`define STAT_VALID_BIT 3
`define STAT_BUSY_BIT 4

// ========================================
// curve codes, iec series
`define IEC_NORMAL_INVERSE_CURVE 3'h0
`define IEC_EXTREMELY_INVERSE_CURVE 3'h1
`define IEC_VERY_INVERSE_CURVE 3'h2
`define IEC_LONG_TIME_INVERSE_CURVE 3'h3
`define IEC_PARAM_CURVE 3'h4
// curve codes, ieee series
`define ANSI_NORMAL_INVERSE_CURVE 3'h0
`define ANSI_VERY_INVERSE_CURVE 3'h1
`define ANSI_EXTREMELY_INVERSE_CURVE 3'h2
`define ANSI_LONG_TIME_INVERSE_CURVE 3'h3
`define IEEE_MODERATELY_INVERSE_CURVE 3'h4
`define IEEE_VERY_INVERSE_CURVE 3'h5
`define IEEE_EXTREMELY_INVERSE_CURVE 3'h6
`define IEEE_PARAM_CURVE 3'h7

// ========================================
// reset values and ranges (register units)
`define DEF_DELAY_RESET 19'h00008
`define DEF_DELAY_MAX 19'h57E40
`define DEF_DELAY_STEP_MS 3'h5
`define TIME_DIAL_RESET 12'h005
`define TIME_DIAL_MAX 12'h9C4
`define CONST_A_RESET 22'h00035C
`define CONST_B_RESET 22'h00073A
`define CONST_C_RESET 22'h0000C8
`define CONST_MAX 22'h2625A0

// ========================================
// standard curve constants, units of 0.00001
`define IEC_NI_A 25'h00036B0
`define IEC_NI_B 25'h00007D0
`define IEC_EI_A 25'h07A1200
`define IEC_EI_B 25'h0030D40
`define IEC_VI_A 25'h0149970
`define IEC_VI_B 25'h00186A0
`define IEC_LTI_A 25'h0B71B00
`define IEC_LTI_B 25'h00186A0
`define ANSI_NI_A 25'h00DA1D8
`define ANSI_NI_B 25'h0004632
`define ANSI_NI_C 25'h00331F8
`define ANSI_VI_A 25'h005FC08
`define ANSI_VI_B 25'h000265C
`define ANSI_VI_C 25'h0030D40
`define ANSI_EI_A 25'h0089B20
`define ANSI_EI_B 25'h0000982
`define ANSI_EI_C 25'h0030D40
`define ANSI_LTI_A 25'h00890F8
`define ANSI_LTI_B 25'h00355E8
`define ANSI_LTI_C 25'h00186A0
`define IEEE_MI_A 25'h000141E
`define IEEE_MI_B 25'h0002C88
`define IEEE_MI_C 25'h00007D0
`define IEEE_VI_A 25'h01DEC28
`define IEEE_VI_B 25'h000BFCC
`define IEEE_VI_C 25'h0030D40
`define IEEE_EI_A 25'h02B07A0
`define IEEE_EI_B 25'h0002F8A
`define IEEE_EI_C 25'h0030D40

// ========================================
// arithmetic constants
`define RECIP_1E5_Q32 17'h0A7C6
`define UNITS_PER_MS 14'h2710
`define ONE_Q16 32'h00010000
`define RESET_RATIO_PCT 7'h61
`define FULL_PCT 7'h64

// ========================================
// timing
`define CLK_PERIOD_NS 10
`define PROG_CYCLE_NS 1000000
`define NS_PER_MS 1000000

`endif

/* hw/seq_divider.v */
// ========================================
// restoring divider, one quotient bit per clock
// divide by zero yields all ones, which reads as an endless delay
module seq_divider #(
	parameter W = 32
) (
	input wire pclk,
	input wire presetn,
	input wire start,
	input wire [W-1:0] dividend,
	input wire [W-1:0] divisor,
	output reg busy,
	output reg done,
	output reg [W-1:0] quotient
);
	reg [W:0] rem;
	reg [W-1:0] quo;
	reg [W-1:0] dvs;
	reg [7:0] count;
	wire [W:0] shifted = {rem[W-1:0], quo[W-1]};
	wire [W:0] trial = shifted - {1'b0, dvs};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem <= {(W+1){1'b0}};
			quo <= {W{1'b0}};
			dvs <= {W{1'b0}};
			count <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			quotient <= {W{1'b0}};
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				rem <= {(W+1){1'b0}};
				quo <= dividend;
				dvs <= divisor;
				count <= W[7:0];
				busy <= 1'b1;
			end else if (busy) begin
				if (trial[W]) begin
					rem <= shifted;
					quo <= {quo[W-2:0], 1'b0};
				end else begin
					rem <= trial;
					quo <= {quo[W-2:0], 1'b1};
				end
				count <= count - 8'h01;
				if (count == 8'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
					quotient <= trial[W] ? {quo[W-2:0], 1'b0} : {quo[W-2:0], 1'b1};
				end
			end
		end
	end
endmodule // seq_divider

/* hw/trip_delay_timer.v */
`include "trip_timer_consts.vh"

// Contract
// - instant, definite or inverse trip delay
// - instant trip asserts with start
// - definite delay independent of measured magnitude
// - inverse delay from ratio and curve
// - definite setting bounds inverse minimum; zero removes
// - delay type selector, definite after reset
// - definite delay 5 ms steps, default 40 ms
// - zero definite delay trips instantly
// - series iec or ieee, default iec
// - iec curves plus parametric a,b, default normal
// - ansi, ieee curves plus parametric a,b,c
// - time dial k scales inverse curves
// - constant a, parametric only, default 0.0860
// - constant b, parametric only, default 0.1850
// - constant c, ieee parametric, default 0.0200
// - iec delay k*a/(m^b-1)
// - ieee delay k*(a/(m^c-1)+b)
// - start clears below 97 percent of setting
module trip_delay_timer #(
	parameter CYCLE_CLKS = `PROG_CYCLE_NS / `CLK_PERIOD_NS,
	parameter CYCLE_MS = `PROG_CYCLE_NS / `NS_PER_MS
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [15:0] pickup_setting,
	input wire [15:0] measured_value,
	input wire block_in,
	output reg start_out,
	output reg blocked_out,
	output wire trip_out
);
	// ========================================
	// state codes of the inverse computation
	localparam S_IDLE = 3'b001;
	localparam S_RATIO = 3'b010;
	localparam S_DELAY = 3'b100;

	// ========================================
	// settings
	reg inverse_time_mode;
	reg series_ieee;
	reg [2:0] curve_sel;
	reg [18:0] def_delay;
	reg [11:0] time_dial;
	reg [21:0] const_a;
	reg [21:0] const_b;
	reg [21:0] const_c;

	wire wr_en = psel && penable && pwrite;
	wire [31:0] wr_val = pwdata;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inverse_time_mode <= 1'b0;
			series_ieee <= 1'b0;
			curve_sel <= 3'h0;
			def_delay <= `DEF_DELAY_RESET;
			time_dial <= `TIME_DIAL_RESET;
			const_a <= `CONST_A_RESET;
			const_b <= `CONST_B_RESET;
			const_c <= `CONST_C_RESET;
		end else if (wr_en) begin
			// out-of-range writes saturate at the top of range
			case (paddr)
				`REG_CTRL: begin
					inverse_time_mode <= wr_val[`CTRL_MODE_BIT];
					series_ieee <= wr_val[`CTRL_SERIES_BIT];
					curve_sel <= wr_val[`CTRL_CURVE_MSB:`CTRL_CURVE_LSB];
				end
				`REG_DEF_DELAY: begin
					def_delay <= (wr_val > {13'h0, `DEF_DELAY_MAX}) ?
						`DEF_DELAY_MAX : wr_val[18:0];
				end
				`REG_TIME_DIAL: begin
					time_dial <= (wr_val > {20'h0, `TIME_DIAL_MAX}) ?
						`TIME_DIAL_MAX : wr_val[11:0];
				end
				`REG_CONST_A: begin
					const_a <= (wr_val > {10'h0, `CONST_MAX}) ? `CONST_MAX : wr_val[21:0];
				end
				`REG_CONST_B: begin
					const_b <= (wr_val > {10'h0, `CONST_MAX}) ? `CONST_MAX : wr_val[21:0];
				end
				`REG_CONST_C: begin
					const_c <= (wr_val > {10'h0, `CONST_MAX}) ? `CONST_MAX : wr_val[21:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ========================================
	// program cycle tick
	reg [31:0] cycle_cnt;
	reg tick;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_cnt <= 32'h00000000;
			tick <= 1'b0;
		end else if (cycle_cnt == CYCLE_CLKS - 1) begin
			cycle_cnt <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			cycle_cnt <= cycle_cnt + 32'h00000001;
			tick <= 1'b0;
		end
	end

	// ========================================
	// pick-up with reset hysteresis
	wire over_setting = measured_value >= pickup_setting;
	wire [22:0] meas_pct = measured_value * `FULL_PCT;
	wire [22:0] reset_level = pickup_setting * `RESET_RATIO_PCT;
	wire hold_level = meas_pct >= reset_level;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_out <= 1'b0;
			blocked_out <= 1'b0;
		end else begin
			blocked_out <= block_in && over_setting;
			if (block_in)
				start_out <= 1'b0;
			else if (over_setting)
				start_out <= 1'b1;
			else if (!hold_level)
				start_out <= 1'b0;
		end
	end

	// ========================================
	// curve constant selection, units of 0.00001
	reg [24:0] sel_a;
	reg [24:0] sel_b;
	reg [24:0] sel_e;
	wire [24:0] user_a = const_a * 4'hA;
	wire [24:0] user_b = const_b * 4'hA;
	wire [24:0] user_c = const_c * 4'hA;

	always @* begin
		sel_a = `IEC_NI_A;
		sel_b = 25'h0;
		sel_e = `IEC_NI_B;
		if (!series_ieee) begin
			case (curve_sel)
				`IEC_EXTREMELY_INVERSE_CURVE: begin
					sel_a = `IEC_EI_A;
					sel_e = `IEC_EI_B;
				end
				`IEC_VERY_INVERSE_CURVE: begin
					sel_a = `IEC_VI_A;
					sel_e = `IEC_VI_B;
				end
				`IEC_LONG_TIME_INVERSE_CURVE: begin
					sel_a = `IEC_LTI_A;
					sel_e = `IEC_LTI_B;
				end
				`IEC_PARAM_CURVE: begin
					sel_a = user_a;
					sel_e = user_b;
				end
				default: begin
					sel_a = `IEC_NI_A;
					sel_e = `IEC_NI_B;
				end
			endcase
		end else begin
			case (curve_sel)
				`ANSI_VERY_INVERSE_CURVE: begin
					sel_a = `ANSI_VI_A;
					sel_b = `ANSI_VI_B;
					sel_e = `ANSI_VI_C;
				end
				`ANSI_EXTREMELY_INVERSE_CURVE: begin
					sel_a = `ANSI_EI_A;
					sel_b = `ANSI_EI_B;
					sel_e = `ANSI_EI_C;
				end
				`ANSI_LONG_TIME_INVERSE_CURVE: begin
					sel_a = `ANSI_LTI_A;
					sel_b = `ANSI_LTI_B;
					sel_e = `ANSI_LTI_C;
				end
				`IEEE_MODERATELY_INVERSE_CURVE: begin
					sel_a = `IEEE_MI_A;
					sel_b = `IEEE_MI_B;
					sel_e = `IEEE_MI_C;
				end
				`IEEE_VERY_INVERSE_CURVE: begin
					sel_a = `IEEE_VI_A;
					sel_b = `IEEE_VI_B;
					sel_e = `IEEE_VI_C;
				end
				`IEEE_EXTREMELY_INVERSE_CURVE: begin
					sel_a = `IEEE_EI_A;
					sel_b = `IEEE_EI_B;
					sel_e = `IEEE_EI_C;
				end
				`IEEE_PARAM_CURVE: begin
					sel_a = user_a;
					sel_b = user_b;
					sel_e = user_c;
				end
				default: begin
					sel_a = `ANSI_NI_A;
					sel_b = `ANSI_NI_B;
					sel_e = `ANSI_NI_C;
				end
			endcase
		end
	end

	// ========================================
	// ratio m = measured / setting in q16.16
	reg [2:0] state;
	reg ratio_go;
	reg delay_go;
	wire ratio_busy;
	wire ratio_done;
	wire [31:0] ratio;
	wire delay_busy;
	wire delay_done;
	wire [79:0] delay_q;

	seq_divider #(.W(32)) u_ratio_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(ratio_go),
		.dividend({measured_value, 16'h0000}),
		.divisor({16'h0000, pickup_setting}),
		.busy(ratio_busy),
		.done(ratio_done),
		.quotient(ratio)
	);

	// ========================================
	// m^e by log2/exp2 with linear segments; error reaches about 30 percent for small fractional exponents
	reg [4:0] msb;
	integer i;

	always @* begin
		msb = 5'h0;
		for (i = 0; i < 32; i = i + 1) begin
			if (ratio[i])
				msb = i[4:0];
		end
	end

	wire [31:0] norm = ratio << (5'h1F - msb);
	wire [5:0] log_int = {1'b0, msb} - 6'h10;
	wire signed [21:0] log_q = {log_int, norm[30:15]};
	wire signed [47:0] pow_p1 = $signed({1'b0, sel_e}) * log_q;
	wire signed [71:0] pow_p2 = pow_p1 * $signed({1'b0, `RECIP_1E5_Q32});
	wire signed [31:0] pow_y = pow_p2[63:32];
	wire y_pos = (pow_y > 32'sh0) && (ratio != 32'h0);
	// above 2^16 the a/excess part of the delay is far below one program cycle, so saturate
	wire y_big = pow_y[31:20] != 12'h000;
	wire [31:0] pow_m = {15'h0000, 1'b1, pow_y[15:0]} << pow_y[19:16];
	wire [31:0] excess = y_big ? 32'hFFFFFFFF : pow_m - `ONE_Q16;

	// ========================================
	// delay in ms = k*(a*2^16 + b*excess) / (10000*excess)
	wire [36:0] k_a = time_dial * sel_a;
	wire [36:0] k_b = time_dial * sel_b;
	wire [79:0] delay_num = {27'h0, k_a, 16'h0000} + k_b * excess;
	wire [79:0] delay_den = excess * `UNITS_PER_MS;

	seq_divider #(.W(80)) u_delay_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(delay_go),
		.dividend(delay_num),
		.divisor(delay_den),
		.busy(delay_busy),
		.done(delay_done),
		.quotient(delay_q)
	);

	reg [31:0] inv_delay;
	reg delay_valid;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			ratio_go <= 1'b0;
			delay_go <= 1'b0;
			inv_delay <= 32'hFFFFFFFF;
			delay_valid <= 1'b0;
		end else begin
			ratio_go <= 1'b0;
			delay_go <= 1'b0;
			if (!start_out)
				delay_valid <= 1'b0;
			case (state)
				S_IDLE: begin
					// recomputed each program cycle as the ratio moves
					if (tick && start_out && inverse_time_mode) begin
						ratio_go <= 1'b1;
						state <= S_RATIO;
					end
				end
				S_RATIO: begin
					if (ratio_done) begin
						if (y_pos) begin
							delay_go <= 1'b1;
							state <= S_DELAY;
						end else begin
							delay_valid <= 1'b0; // ratio at or below one never trips
							state <= S_IDLE;
						end
					end
				end
				S_DELAY: begin
					if (delay_done) begin
						inv_delay <= (delay_q[79:32] != 48'h0) ? 32'hFFFFFFFF : delay_q[31:0];
						delay_valid <= start_out;
						state <= S_IDLE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ========================================
	// operating time counter and trip
	reg [31:0] elapsed;
	reg trip_hold;
	wire [31:0] def_ms = def_delay * `DEF_DELAY_STEP_MS;
	wire def_zero = def_delay == 19'h0;
	wire dt_reached = !def_zero && (elapsed >= def_ms);
	wire inv_reached = delay_valid && (elapsed >= inv_delay) && (elapsed >= def_ms);
	wire instant = start_out && !inverse_time_mode && def_zero;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			elapsed <= 32'h00000000;
			trip_hold <= 1'b0;
		end else if (!start_out) begin
			elapsed <= 32'h00000000;
			trip_hold <= 1'b0;
		end else begin
			if (tick && (elapsed < 32'hFFFFFFFF - CYCLE_MS))
				elapsed <= elapsed + CYCLE_MS;
			if (inverse_time_mode ? inv_reached : dt_reached)
				trip_hold <= 1'b1;
		end
	end

	// instant trip rides on start in the same cycle
	assign trip_out = trip_hold || instant;

	// ========================================
	// apb read path, zero wait states
	reg addr_ok;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			addr_ok <= 1'b0;
		end else if (psel && !penable) begin
			addr_ok <= 1'b1;
			case (paddr)
				`REG_CTRL: prdata <= {25'h0, curve_sel, 2'h0, series_ieee, inverse_time_mode};
				`REG_DEF_DELAY: prdata <= {13'h0, def_delay};
				`REG_TIME_DIAL: prdata <= {20'h0, time_dial};
				`REG_CONST_A: prdata <= {10'h0, const_a};
				`REG_CONST_B: prdata <= {10'h0, const_b};
				`REG_CONST_C: prdata <= {10'h0, const_c};
				`REG_STATUS: prdata <= {27'h0, (state != S_IDLE), delay_valid,
					blocked_out, trip_out, start_out};
				`REG_ELAPSED: prdata <= elapsed;
				`REG_INV_DELAY: prdata <= inv_delay;
				default: begin
					prdata <= 32'h00000000;
					addr_ok <= 1'b0;
				end
			endcase
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
endmodule // trip_delay_timer

/* tb/trip_delay_timer_sva.sv */
module trip_delay_timer_sva #(
	parameter CYCLE_CLKS = 100000,
	parameter CYCLE_MS = 1
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [15:0] pickup_setting,
	input wire [15:0] measured_value,
	input wire block_in,
	input wire start_out,
	input wire blocked_out,
	input wire trip_out
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ========================================
	// shadow of the settings that decide trip timing
	reg mode_s;
	reg [18:0] def_s;
	reg [31:0] cnt;
	wire wr = psel & penable & pwrite;
	wire [31:0] m100 = {16'h0000, measured_value} * 32'h00000064;
	wire [31:0] s97 = {16'h0000, pickup_setting} * 32'h00000061;
	wire [31:0] dclk = {13'h0000, def_s} * 32'h00000005 / CYCLE_MS * CYCLE_CLKS;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_s <= 1'b0;
			def_s <= 19'h00008;
			cnt <= 32'h00000000;
		end else begin
			if (wr && paddr == 8'h00) begin
				mode_s <= pwdata[0];
			end
			if (wr && paddr == 8'h04) begin
				def_s <= pwdata[18:0];
			end
			cnt <= start_out ? cnt + 32'h00000001 : 32'h00000000;
		end
	end
	// ========================================
	// pick-up level with 97 percent release
	sequence hold_s;
		start_out && !block_in && m100 >= s97;
	endsequence
	sequence drop_s;
		start_out && m100 < s97;
	endsequence
	// ========================================
	// assertions
	instant_trip_a: assert property (start_out && !mode_s && def_s == 19'h00000 |-> trip_out)
		else $error("instant trip missing");
	// tick phase is free running, so allow one tick of slack below
	def_time_a: assert property ($rose(trip_out) && !mode_s && def_s != 19'h00000
		|-> cnt + CYCLE_CLKS + 2 >= dclk && cnt <= dclk + 6)
		else $error("definite trip time off");
	start_hold_a: assert property (hold_s |=> start_out)
		else $error("start lost inside hysteresis");
	start_drop_a: assert property (drop_s |=> !start_out)
		else $error("start kept below release level");
	trip_hold_a: assert property (trip_out ##0 hold_s |=> trip_out)
		else $error("trip dropped while start held");
	trip_start_a: assert property (!start_out [*2] |-> !trip_out)
		else $error("trip without start");
	pickup_start_a: assert property (!block_in && measured_value >= pickup_setting |=> start_out)
		else $error("start missing at pick-up");
	unmapped_err_a: assert property (psel && penable && paddr > 8'h20 |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
endmodule // trip_delay_timer_sva

bind trip_delay_timer trip_delay_timer_sva #(.CYCLE_CLKS(CYCLE_CLKS), .CYCLE_MS(CYCLE_MS)) sva_u (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pickup_setting(pickup_setting), .measured_value(measured_value), .block_in(block_in),
	.start_out(start_out), .blocked_out(blocked_out), .trip_out(trip_out)
);

/* tb/pickup_model.sv */
module pickup_model #(
	parameter logic [15:0] SETTING = 16'h03E8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] level,
	input wire logic blk,
	output logic [15:0] pickup_setting,
	output logic [15:0] measured_value,
	output logic block_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========================================
	// measurement result lands one cycle late, as a computed sample would
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			measured_value <= 16'h0000;
			block_in <= 1'b0;
		end else begin
			measured_value <= level;
			block_in <= blk;
		end
	end
	assign pickup_setting = SETTING;
endmodule // pickup_model

/* tb/test_trip_delay_timer.sv */
module test_trip_delay_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, blk, serr;
	logic pready, pslverr, start_out, blocked_out, trip_out, block_in;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] level, pickup_setting, measured_value;
	int err_count, cmp_count, ncyc, tick;
	trip_delay_timer #(.CYCLE_CLKS(10), .CYCLE_MS(1)) dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pickup_setting(pickup_setting), .measured_value(measured_value), .block_in(block_in),
		.start_out(start_out), .blocked_out(blocked_out), .trip_out(trip_out));
	pickup_model pm_u (.pclk(pclk), .presetn(presetn), .level(level), .blk(blk),
		.pickup_setting(pickup_setting), .measured_value(measured_value), .block_in(block_in));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ========================================
	// shared tasks
	task test_done;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		tick <= tick + 1;
		if (tick == 40000) begin
			err_count++;
			test_done;
		end
	end
	task chk(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
		logic ok;
		ok = (g >= lo) && (g <= hi);
		cmp_count++;
		if (ok !== 1'b1) begin
			$display("Error %s expected %0d..%0d seen %0d", n, lo, hi, g);
			err_count++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task trip_time(input logic [15:0] m, input int lim);
		int n;
		level <= m;
		n = 0;
		while (start_out !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		ncyc = 0;
		while (trip_out !== 1'b1 && ncyc < lim) begin
			@(posedge pclk);
			ncyc++;
		end
	endtask
	task drop;
		level <= 16'h0000;
		repeat (4) @(posedge pclk);
		chk("start after drop", 0, 0, start_out);
		chk("trip after drop", 0, 0, trip_out);
	endtask
	// within e/32+2 ms where the exponent is whole; approximate log math gets a wide band
	task inv_delay(input logic [7:0] c, input int e);
		int t;
		level <= 16'h0000;
		repeat (3) @(posedge pclk);
		apb(1'b1, 8'h00, {24'h000000, c});
		level <= 16'h07D0;
		repeat (250) @(posedge pclk);
		apb(1'b0, 8'h20, 32'h00000000);
		t = e < 0 ? -e / 2 : e / 32 + 2;
		e = e < 0 ? -e : e;
		chk("inverse delay ms", e - t, e + t, rd);
	endtask
	// ========================================
	// scenarios
	task t_reset;
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
		logic [31:0] e[6] = '{32'h0, 32'h8, 32'h5, 32'h35C, 32'h73A, 32'hC8};
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, a[i], 32'h00000000);
			chk("reset value", e[i], e[i], rd);
		end
		apb(1'b0, 8'h40, 32'h00000000);
		chk("unmapped error", 1, 1, serr);
	endtask
	task t_definite;
		trip_time(16'h044C, 600);
		chk("definite trip clks", 385, 410, ncyc);
		level <= 16'h03CA;
		repeat (4) @(posedge pclk);
		chk("start at release edge", 1, 1, start_out);
		chk("trip held", 1, 1, trip_out);
		apb(1'b0, 8'h18, 32'h00000000);
		chk("status while tripped", 3, 3, rd);
		drop;
		apb(1'b1, 8'h00, 32'h00000072);
		trip_time(16'h1388, 600);
		chk("definite trip, large input", 385, 410, ncyc);
		drop;
	endtask
	task t_instant;
		apb(1'b1, 8'h04, 32'h00000000);
		trip_time(16'h05DC, 5);
		chk("instant trip clks", 0, 0, ncyc);
		drop;
		apb(1'b1, 8'h04, 32'h00000008);
	endtask
	task t_block;
		blk <= 1'b1;
		level <= 16'h07D0;
		repeat (450) @(posedge pclk);
		chk("blocked start", 0, 0, start_out);
		chk("blocked trip", 0, 0, trip_out);
		chk("blocked flag", 1, 1, blocked_out);
		blk <= 1'b0;
		drop;
	endtask
	task t_inv_trip;
		apb(1'b1, 8'h04, 32'h00000000);
		apb(1'b1, 8'h00, 32'h00000021);
		trip_time(16'h07D0, 9000);
		chk("inverse trip clks", 6600, 6950, ncyc);
		drop;
		apb(1'b1, 8'h04, 32'h000000C8);
		trip_time(16'h07D0, 12000);
		chk("bounded trip clks", 9850, 10150, ncyc);
		drop;
	endtask
	task t_curves;
		logic [7:0] c[13] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h03, 8'h13,
			8'h23, 8'h33, 8'h43, 8'h53, 8'h63, 8'h73};
		int e[13] = '{-501, 1333, 675, 6000, -31, -145, 70, 95, 390, -190, 351, 476, -317};
		for (int i = 0; i < 13; i++) begin
			inv_delay(c[i], e[i]);
		end
		apb(1'b1, 8'h0C, 32'h00007530);
		apb(1'b1, 8'h10, 32'h00000000);
		apb(1'b1, 8'h14, 32'h00004E20);
		inv_delay(8'h73, 50);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		level = 16'h0000;
		blk = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_definite;
		t_instant;
		t_block;
		t_inv_trip;
		t_curves;
		test_done;
	end
endmodule // test_trip_delay_timer
